// ===== adc_ctrl_pkg.sv
// Constants shared by the converter control block
package adc_ctrl_pkg;
   // ========================================
   // Register byte offsets
   localparam logic [7:0] OFF_POS_SEL   = 8'h00;
   localparam logic [7:0] OFF_NEG_SEL   = 8'h04;
   localparam logic [7:0] OFF_STATUS    = 8'h08;
   localparam logic [7:0] OFF_RESULT    = 8'h0C;
   localparam logic [7:0] OFF_SOFT_RST  = 8'h10;
   localparam logic [7:0] OFF_MODE      = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h18;
   // ========================================
   // Field positions
   localparam int SEL_MSB      = 4;
   localparam int RESULT_LSB   = 16;
   localparam int RESULT_MSB   = 27;
   localparam int RESULT_W     = 12;
   localparam int DONE_BIT     = 0;
   localparam int RST_BIT      = 0;
   localparam int MODE_START   = 0;
   localparam int MODE_LSB     = 1;
   localparam int MODE_MSB     = 2;
   localparam int ACQ_LSB      = 3;
   localparam int ACQ_MSB      = 4;
   localparam int DIV_LSB      = 5;
   localparam int DIV_MSB      = 7;
   // ========================================
   // Reset values
   localparam logic [4:0] SEL_RESET  = 5'h00;
   localparam logic [1:0] ACQ_RESET  = 2'h2;
   localparam logic [2:0] DIV_RESET  = 3'h1;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // ========================================
   // Channel codes
   localparam logic [4:0] CH_LAST_EXT = 5'h0D;
   localparam logic [4:0] CH_TEMP     = 5'h10;
   localparam logic [4:0] CH_AGND     = 5'h11;
   localparam logic [4:0] CH_VREF     = 5'h12;
   localparam logic [4:0] CH_HALFAVDD = 5'h13;
   // ========================================
   // Conversion modes
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_DIFF   = 2'h1;
   localparam logic [1:0] MODE_PSEUDO = 2'h2;
   // ========================================
   // Timing: conversion length in converter clocks
   localparam int CONV_CLOCKS = 19;
endpackage

// ===== sar_step_core.sv
// Successive approximation bit stepper
`timescale 1ns/1ns
module sar_step_core #(
   parameter int WIDTH = 12
) (
   input  wire logic             sys_clk,   // System clock
   input  wire logic             arst_n,    // Async reset, low
   input  wire logic             clr,       // Synchronous clear
   input  wire logic             begin_i,   // Start a new search
   input  wire logic             stepEn,    // One trial per pulse
   input  wire logic             cmpHigh,   // Input above trial level
   output logic [WIDTH-1:0]      trialCode, // Code under trial
   output logic                  finished   // Last bit decided
);
   logic [WIDTH-1:0] bitPtr_r;

   // ========================================
   // Trial register: set a bit, keep or drop by comparator
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         trialCode <= '0;
         bitPtr_r  <= '0;
         finished  <= 1'b0;
      end else if (clr) begin
         trialCode <= '0;
         bitPtr_r  <= '0;
         finished  <= 1'b0;
      end else if (begin_i) begin
         bitPtr_r  <= {1'b1, {(WIDTH-1){1'b0}}};
         trialCode <= {1'b1, {(WIDTH-1){1'b0}}};
         finished  <= 1'b0;
      end else if (stepEn && bitPtr_r != '0) begin
         // Drop the trial bit when the input sits below it
         trialCode <= (cmpHigh ? trialCode : (trialCode & ~bitPtr_r))
                      | (bitPtr_r >> 1);
         bitPtr_r  <= bitPtr_r >> 1;
         finished  <= (bitPtr_r[0] == 1'b1);
      end else begin
         finished  <= 1'b0;
      end
   end
endmodule

// ===== adc_channel_select_result_if.sv
// Converter channel select, sequencing and result registers on APB
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
// Behaviour
// [R1] Positive input follows a 5-bit code: 0-13 pins, 16 temp, 17 ground, 18 reference, 19 half supply, rest reserved.
// [R2] Negative input follows its own 5-bit code: 0-13 pins, 16 temp, rest reserved.
// [R3] Status bit 0 sets by itself when a conversion finishes.
// [R4] Reading the result register clears status bit 0.
// [R5] The 12-bit result sits in bits 27:16 of the result register.
// [R6] Writing 1 to bit 0 of the reset register returns all registers to defaults.
// [R7] During acquisition the comparator is held balanced while inputs are tracked.
// [R8] From conversion start both sampled inputs stay off the pins.
// [R9] The logic steps approximation trials, completes, then outputs the code.
// [R10] Pseudo-differential: negative switch on channel in acquisition, reference in conversion.
// [R11] Single-ended: negative switch tied to internal ground.
// [R12] A conversion takes 19 converter clocks plus the acquisition time.
// [R13] Reserved select bits and result bits outside the field read zero.
module adc_channel_select_result_if #(
   parameter int RES_W = 12
) (
   input  wire logic        sys_clk,       // 50 MHz system clock
   input  wire logic        arst_n,        // Async reset, low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB access phase
   input  wire logic        pwrite,        // APB direction
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        cmpHigh,       // Comparator output pin
   output logic [4:0]       posMux,        // Positive mux code
   output logic [4:0]       negMux,        // Negative mux code
   output logic             negToRef,      // Negative side on reference
   output logic             negToGnd,      // Negative side on ground
   output logic             inputsConn,    // Sampling switches closed
   output logic             comparatorBal, // Balance switch closed
   output logic [RES_W-1:0] dacCode,       // Capacitive DAC trial code
   output logic             irq            // Level interrupt
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACQ  = 3'b010,
      ST_CONV = 3'b100
   } seq_t;

   seq_t             state_r;
   logic [4:0]       posSel_r, negSel_r;
   logic [1:0]       mode_r, acq_r;
   logic [2:0]       div_r;
   logic             cont_r, done_r, irqMask_r;
   logic [RES_W-1:0] result_r;
   logic [5:0]       divCnt_r;
   logic [4:0]       phaseCnt_r;
   logic             adcTick, softRst, wrEn, rdEn;
   logic             cmpS1_r, cmpS2_r, cmpS3_r, cmpLvl_r;
   logic [RES_W-1:0] trialCode;
   logic             sarDone, startReq;
   logic [4:0]       acqLen;

   assign wrEn    = psel && penable && pwrite;
   assign rdEn    = psel && penable && !pwrite;
   assign softRst = wrEn && paddr == adc_ctrl_pkg::OFF_SOFT_RST
                    && pwdata[adc_ctrl_pkg::RST_BIT];
   assign startReq = wrEn && paddr == adc_ctrl_pkg::OFF_MODE
                     && pwdata[adc_ctrl_pkg::MODE_START];
   assign acqLen  = 5'd2 << acq_r;

   // ========================================
   // Comparator pin synchroniser; change counts when stages 2 and 3 agree
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmpS1_r  <= 1'b0;
         cmpS2_r  <= 1'b0;
         cmpS3_r  <= 1'b0;
         cmpLvl_r <= 1'b0;
      end else begin
         cmpS1_r <= cmpHigh;
         cmpS2_r <= cmpS1_r;
         cmpS3_r <= cmpS2_r;
         if (cmpS2_r == cmpS3_r) begin
            cmpLvl_r <= cmpS3_r;
         end
      end
   end

   // ========================================
   // Converter clock enable: core clock divided by 2**div
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         divCnt_r <= '0;
      end else if (adcTick || softRst) begin
         divCnt_r <= '0;
      end else begin
         divCnt_r <= divCnt_r + 6'd1;
      end
   end
   // At or above the limit ticks at once, so a smaller divide never stalls
   assign adcTick = divCnt_r >= ((6'd1 << div_r) - 6'd1);

   // ========================================
   // Configuration registers, soft reset restores defaults
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         posSel_r  <= adc_ctrl_pkg::SEL_RESET;
         negSel_r  <= adc_ctrl_pkg::SEL_RESET;
         mode_r    <= adc_ctrl_pkg::MODE_RESET;
         acq_r     <= adc_ctrl_pkg::ACQ_RESET;
         div_r     <= adc_ctrl_pkg::DIV_RESET;
         irqMask_r <= 1'b0;
      end else if (softRst) begin // see [R6]
         posSel_r  <= adc_ctrl_pkg::SEL_RESET;
         negSel_r  <= adc_ctrl_pkg::SEL_RESET;
         mode_r    <= adc_ctrl_pkg::MODE_RESET;
         acq_r     <= adc_ctrl_pkg::ACQ_RESET;
         div_r     <= adc_ctrl_pkg::DIV_RESET;
         irqMask_r <= 1'b0;
      end else if (wrEn) begin
         case (paddr)
            adc_ctrl_pkg::OFF_POS_SEL: begin
               posSel_r <= pwdata[adc_ctrl_pkg::SEL_MSB:0];
            end
            adc_ctrl_pkg::OFF_NEG_SEL: begin
               negSel_r <= pwdata[adc_ctrl_pkg::SEL_MSB:0];
            end
            adc_ctrl_pkg::OFF_MODE: begin
               mode_r <= pwdata[adc_ctrl_pkg::MODE_MSB:adc_ctrl_pkg::MODE_LSB];
               acq_r  <= pwdata[adc_ctrl_pkg::ACQ_MSB:adc_ctrl_pkg::ACQ_LSB];
               // Divide beyond 32 is clamped; counter is only 6 bits
               div_r  <= (pwdata[adc_ctrl_pkg::DIV_MSB:adc_ctrl_pkg::DIV_LSB]
                          > 3'd5) ? 3'd5 :
                         pwdata[adc_ctrl_pkg::DIV_MSB:adc_ctrl_pkg::DIV_LSB];
            end
            adc_ctrl_pkg::OFF_IRQ_MASK: begin
               irqMask_r <= pwdata[adc_ctrl_pkg::DONE_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // ========================================
   // Phase sequencer: acquisition then 19-clock conversion
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r    <= ST_IDLE;
         phaseCnt_r <= '0;
      end else if (softRst) begin
         state_r    <= ST_IDLE;
         phaseCnt_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (startReq) begin
                  state_r    <= ST_ACQ;
                  phaseCnt_r <= '0;
               end
            end
            ST_ACQ: begin
               if (adcTick) begin
                  if (phaseCnt_r == acqLen - 5'd1) begin // see [R12]
                     state_r    <= ST_CONV;
                     phaseCnt_r <= '0;
                  end else begin
                     phaseCnt_r <= phaseCnt_r + 5'd1;
                  end
               end
            end
            ST_CONV: begin
               if (adcTick) begin
                  if (phaseCnt_r == 5'(adc_ctrl_pkg::CONV_CLOCKS - 1)) begin
                     state_r    <= ST_IDLE; // see [R12]
                     phaseCnt_r <= '0;
                  end else begin
                     phaseCnt_r <= phaseCnt_r + 5'd1;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Trials run on converter clocks 1..12 of the conversion phase
   sar_step_core #(.WIDTH(RES_W)) uSar (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .clr       (softRst),
      .begin_i   (state_r == ST_ACQ && adcTick
                  && phaseCnt_r == acqLen - 5'd1),
      .stepEn    (state_r == ST_CONV && adcTick
                  && phaseCnt_r < 5'(RES_W)), // see [R9]
      .cmpHigh   (cmpLvl_r),
      .trialCode (trialCode),
      .finished  (sarDone)
   );

   // ========================================
   // Result capture and sticky done flag; set wins over read clear
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         result_r <= '0;
         done_r   <= 1'b0;
      end else if (softRst) begin
         result_r <= '0;
         done_r   <= 1'b0;
      end else begin
         if (state_r == ST_CONV && adcTick
             && phaseCnt_r == 5'(adc_ctrl_pkg::CONV_CLOCKS - 1)) begin
            result_r <= trialCode; // see [R9]
            done_r   <= 1'b1;      // see [R3]
         end else if (rdEn && paddr == adc_ctrl_pkg::OFF_RESULT) begin
            done_r <= 1'b0;        // see [R4]
         end
      end
   end

   // ========================================
   // Analog switch controls, all registered
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         posMux        <= adc_ctrl_pkg::SEL_RESET;
         negMux        <= adc_ctrl_pkg::SEL_RESET;
         negToRef      <= 1'b0;
         negToGnd      <= 1'b1;
         inputsConn    <= 1'b1;
         comparatorBal <= 1'b1;
         dacCode       <= '0;
         irq           <= 1'b0;
      end else begin
         // Reserved codes leave the previous routing untouched
         if (posSel_r <= adc_ctrl_pkg::CH_LAST_EXT
             || (posSel_r >= adc_ctrl_pkg::CH_TEMP
                 && posSel_r <= adc_ctrl_pkg::CH_HALFAVDD)) begin
            posMux <= posSel_r; // see [R1]
         end
         if (negSel_r <= adc_ctrl_pkg::CH_LAST_EXT
             || negSel_r == adc_ctrl_pkg::CH_TEMP) begin
            negMux <= negSel_r; // see [R2]
         end
         comparatorBal <= state_r != ST_CONV; // see [R7]
         inputsConn    <= state_r != ST_CONV; // see [R8]
         negToGnd <= mode_r == adc_ctrl_pkg::MODE_SINGLE; // see [R11]
         negToRef <= mode_r == adc_ctrl_pkg::MODE_PSEUDO
                     && state_r == ST_CONV; // see [R10]
         dacCode <= trialCode;
         irq     <= done_r && irqMask_r;
      end
   end

   // ========================================
   // APB read mux and answer; zero wait, errors on unmapped addresses
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable) begin
            case (paddr)
               adc_ctrl_pkg::OFF_POS_SEL: prdata <= {27'h0, posSel_r}; // see [R13]
               adc_ctrl_pkg::OFF_NEG_SEL: prdata <= {27'h0, negSel_r}; // see [R13]
               adc_ctrl_pkg::OFF_STATUS:  prdata <= {31'h0, done_r};
               adc_ctrl_pkg::OFF_RESULT:  prdata <= {4'h0, result_r, 16'h0}; // see [R5]
               adc_ctrl_pkg::OFF_MODE:    prdata <= {24'h0, div_r, acq_r,
                                                     mode_r, 1'b0};
               adc_ctrl_pkg::OFF_IRQ_MASK: prdata <= {31'h0, irqMask_r};
               adc_ctrl_pkg::OFF_SOFT_RST: prdata <= '0;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ========================================
   // Checks
   sequence convEnd_s;
      state_r == ST_CONV && adcTick
      && phaseCnt_r == 5'(adc_ctrl_pkg::CONV_CLOCKS - 1);
   endsequence

   a_done_sets: assert property (@(posedge sys_clk) disable iff (!arst_n)
      convEnd_s |=> done_r) else $error("done flag not set"); // see [R3]
   a_read_clears: assert property (@(posedge sys_clk) disable iff (!arst_n)
      rdEn && paddr == adc_ctrl_pkg::OFF_RESULT && !softRst
      && !(state_r == ST_CONV && adcTick) |=> !done_r)
      else $error("done flag not cleared"); // see [R4]
   a_result_field: assert property (@(posedge sys_clk) disable iff (!arst_n)
      pready && $past(paddr) == adc_ctrl_pkg::OFF_RESULT
      |-> prdata[31:28] == 4'h0 && prdata[15:0] == 16'h0)
      else $error("result outside field"); // see [R5]
   a_soft_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
      softRst |=> state_r == ST_IDLE && !done_r
      && acq_r == adc_ctrl_pkg::ACQ_RESET)
      else $error("soft reset missed"); // see [R6]
   a_bal_acq: assert property (@(posedge sys_clk) disable iff (!arst_n)
      state_r == ST_ACQ ##1 state_r == ST_ACQ |-> comparatorBal)
      else $error("comparator not balanced"); // see [R7]
   a_conv_open: assert property (@(posedge sys_clk) disable iff (!arst_n)
      state_r == ST_CONV ##1 state_r == ST_CONV |-> !inputsConn)
      else $error("inputs connected in conversion"); // see [R8]
   a_single_gnd: assert property (@(posedge sys_clk) disable iff (!arst_n)
      mode_r == adc_ctrl_pkg::MODE_SINGLE [*2] |-> negToGnd && !negToRef)
      else $error("single-ended not grounded"); // see [R11]
   a_pseudo_ref: assert property (@(posedge sys_clk) disable iff (!arst_n)
      mode_r == adc_ctrl_pkg::MODE_PSEUDO && state_r == ST_ACQ
      ##1 mode_r == adc_ctrl_pkg::MODE_PSEUDO && state_r == ST_ACQ
      |-> !negToRef) else $error("pseudo ref in acquisition"); // see [R10]
   a_neg_legal: assert property (@(posedge sys_clk) disable iff (!arst_n)
      negMux <= adc_ctrl_pkg::CH_LAST_EXT || negMux == adc_ctrl_pkg::CH_TEMP)
      else $error("negative mux reserved"); // see [R2]
   a_conv_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
      state_r == ST_IDLE && startReq
      && pwdata[adc_ctrl_pkg::DIV_MSB:adc_ctrl_pkg::DIV_LSB] == 3'h0
      && pwdata[adc_ctrl_pkg::ACQ_MSB:adc_ctrl_pkg::ACQ_LSB] == 2'h0
      && !softRst |-> ##3 state_r == ST_CONV ##19 state_r == ST_IDLE)
      else $error("conversion length wrong"); // see [R12]
endmodule

// ===== analog_front_model.sv
// Behavioural analog front end: input levels and comparator
`timescale 1ns/1ns
module analog_front_model (
   input  wire logic [4:0]  posMux,  // Positive mux code
   input  wire logic [11:0] dacCode, // Trial code from the DAC
   output logic             cmpHigh  // Comparator decision
);
   // ========================================
   // Source levels
   // Each source has a distinct level so a wrong route shows up
   logic [11:0] level;
   assign level = {posMux, 7'h2B};
   // Comparator is ideal; a real one would add noise near the threshold
   assign cmpHigh = (level >= dacCode);
endmodule

// ===== adc_channel_select_result_if_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_channel_select_result_if_tb;
   // ========================================
   // Signals
   logic        sysClk, arstN, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        cmpHigh, negToRef, negToGnd, inputsConn;
   logic        comparatorBal, irq;
   logic [4:0]  posMux, negMux;
   logic [11:0] dacCode;
   int          miscompares, totalChecks, cycles;
   // Mode register after reset: default divider and acquisition, single
   localparam logic [31:0] MODE_DEF = {24'h0, adc_ctrl_pkg::DIV_RESET,
                                       adc_ctrl_pkg::ACQ_RESET,
                                       adc_ctrl_pkg::MODE_RESET, 1'b0};
   // ========================================
   // Instances
   adc_channel_select_result_if adc_channel_select_result_if_inst (
      .sys_clk(sysClk), .arst_n(arstN), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmpHigh(cmpHigh),
      .posMux(posMux), .negMux(negMux), .negToRef(negToRef),
      .negToGnd(negToGnd), .inputsConn(inputsConn),
      .comparatorBal(comparatorBal), .dacCode(dacCode), .irq(irq));
   analog_front_model analog_front_model_inst (
      .posMux(posMux), .dacCode(dacCode), .cmpHigh(cmpHigh));
   // ========================================
   // Clock and hang guard
   always #10 sysClk = ~sysClk;
   // Whole run is about a thousand cycles; the ceiling leaves wide margin
   always @(posedge sysClk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   // ========================================
   // Tasks
   task automatic final_report();
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge sysClk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sysClk);
      penable <= 1'b1;
      // Ends when pready is seen high; without it only the bench's cycle ceiling ends this wait
      do begin
         @(posedge sysClk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   task automatic reset_vals();
      logic [31:0] q;
      logic        e;
      check("negToGnd", negToGnd, 1'b1);
      check("inputsConn", inputsConn, 1'b1);
      check("comparatorBal", comparatorBal, 1'b1);
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * i), q);
         check("resetValue", q, 32'h0);
      end
      rd(8'h14, q);
      check("modeReset", q, MODE_DEF);
      rd(8'h18, q);
      check("maskReset", q, 32'h0);
      apb(1'b0, 8'h40, 32'h0, q, e);
      check("unmappedErr", e, 1'b1);
   endtask
   task automatic sel_codes();
      logic [31:0] q;
      logic [4:0]  c;
      logic [4:0]  negExp;
      for (int i = 0; i < 20; i++) begin
         if (i == 14 || i == 15) continue;
         c = i[4:0];
         wr(8'h00, {27'h0, c});
         wr(8'h04, {27'h0, c});
         if (i <= 13 || i == 16) negExp = c;
         // Select register, then routing register: two edges to settle
         repeat (2) @(posedge sysClk);
         check("posMux", posMux, c);
         check("negMux", negMux, negExp);
         rd(8'h00, q);
         check("posRead", q, {27'h0, c});
      end
      // Reserved codes must not move the routing
      wr(8'h00, 32'hEE);
      wr(8'h04, 32'hFF);
      repeat (2) @(posedge sysClk);
      check("posMuxKept", posMux, 5'h13);
      check("negMuxKept", negMux, 5'h10);
      rd(8'h00, q);
      check("posReserved", q, 32'h0E);
      rd(8'h04, q);
      check("negReserved", q, 32'h1F);
   endtask
   // Divider 3 gives eight cycles a tick; acquisition code 0 is 2 ticks
   task automatic conv(input logic [1:0] m, input logic [4:0] ch,
                       input logic msk);
      int          n;
      logic [31:0] q;
      wr(8'h18, {31'h0, msk});
      wr(8'h00, {27'h0, ch});
      wr(8'h14, {24'h0, 3'h3, 2'h0, m, 1'b1});
      repeat (4) @(posedge sysClk);
      check("balAcq", comparatorBal, 1'b1);
      check("connAcq", inputsConn, 1'b1);
      check("refAcq", negToRef, 1'b0);
      n = 0;
      while (inputsConn !== 1'b0 && n < 100) begin
         @(posedge sysClk);
         n++;
      end
      check("balConv", comparatorBal, 1'b0);
      check("refConv", negToRef, m == adc_ctrl_pkg::MODE_PSEUDO);
      check("gndTie", negToGnd, m == adc_ctrl_pkg::MODE_SINGLE);
      n = 0;
      while (inputsConn === 1'b0 && n < 400) begin
         @(posedge sysClk);
         n++;
      end
      check("convLen", n, adc_ctrl_pkg::CONV_CLOCKS * 8);
      repeat (4) @(posedge sysClk);
      check("irqLevel", irq, msk);
      rd(8'h08, q);
      check("doneSet", q, 32'h1);
      rd(8'h0C, q);
      check("result", q, {4'h0, ch, 7'h2B, 16'h0});
      rd(8'h08, q);
      check("doneClear", q, 32'h0);
      check("irqClear", irq, 1'b0);
   endtask
   // Divider 0 ticks every cycle, so conversion is exactly 19 cycles;
   // the comparator synchroniser is too slow for that rate, so the code is not judged
   task automatic fast_conv();
      int          n;
      logic [31:0] q;
      wr(8'h14, 32'h01);
      n = 0;
      while (inputsConn !== 1'b0 && n < 40) begin
         @(posedge sysClk);
         n++;
      end
      n = 0;
      while (inputsConn === 1'b0 && n < 40) begin
         @(posedge sysClk);
         n++;
      end
      check("fastLen", n, adc_ctrl_pkg::CONV_CLOCKS);
      repeat (2) @(posedge sysClk);
      rd(8'h08, q);
      check("fastDone", q, 32'h1);
      rd(8'h0C, q);
   endtask
   task automatic soft_reset();
      logic [31:0] q;
      wr(8'h00, 32'h07);
      wr(8'h18, 32'h01);
      wr(8'h14, 32'h61);
      repeat (24) @(posedge sysClk);
      wr(8'h10, 32'h01);
      repeat (2) @(posedge sysClk);
      check("posMuxRst", posMux, 5'h00);
      check("connRst", inputsConn, 1'b1);
      check("balRst", comparatorBal, 1'b1);
      rd(8'h00, q);
      check("posRst", q, 32'h0);
      rd(8'h08, q);
      check("statusRst", q, 32'h0);
      check("irqRst", irq, 1'b0);
      rd(8'h14, q);
      check("modeRst", q, MODE_DEF);
      rd(8'h18, q);
      check("maskRst", q, 32'h0);
   endtask
   // ========================================
   // Main sequence
   initial begin
      sysClk = 1'b0;
      arstN = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      miscompares = 0;
      totalChecks = 0;
      cycles = 0;
      repeat (16) @(posedge sysClk);
      arstN <= 1'b1;
      reset_vals();
      sel_codes();
      conv(adc_ctrl_pkg::MODE_SINGLE, 5'h05, 1'b1);
      conv(adc_ctrl_pkg::MODE_DIFF, 5'h0B, 1'b0);
      conv(adc_ctrl_pkg::MODE_PSEUDO, 5'h10, 1'b1);
      fast_conv();
      soft_reset();
      final_report();
   end
endmodule
